// ===== verilog/gpe_consts.svh
// Register offsets, widths and reset values of the edge-detecting GPIO port
`ifndef GPE_CONSTS_SVH
`define GPE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define GPE_ADDR_W        8
`define GPE_DATA_W        32
`define GPE_BE_W          4
`define GPE_PINS          50
`define GPE_BANK0_W       32
`define GPE_BANK1_W       18

// ----------------------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------------------
`define GPE_OFF_LEVEL0    8'h00
`define GPE_OFF_LEVEL1    8'h04
`define GPE_OFF_DIR0      8'h0C
`define GPE_OFF_DIR1      8'h10
`define GPE_OFF_OSET0     8'h18
`define GPE_OFF_OSET1     8'h1C
`define GPE_OFF_OCLR0     8'h24
`define GPE_OFF_OCLR1     8'h28
`define GPE_OFF_RISE0     8'h30
`define GPE_OFF_RISE1     8'h34
`define GPE_OFF_FALL0     8'h3C
`define GPE_OFF_FALL1     8'h40
`define GPE_OFF_STAT0     8'h48
`define GPE_OFF_STAT1     8'h4C
`define GPE_OFF_DSET0     8'h54
`define GPE_OFF_DSET1     8'h58
`define GPE_OFF_DCLR0     8'h60
`define GPE_OFF_DCLR1     8'h64
`define GPE_OFF_RSET0     8'h6C
`define GPE_OFF_RSET1     8'h70
`define GPE_OFF_RCLR0     8'h78
`define GPE_OFF_RCLR1     8'h7C
`define GPE_OFF_FSET0     8'h84
`define GPE_OFF_FSET1     8'h88
`define GPE_OFF_FCLR0     8'h90
`define GPE_OFF_FCLR1     8'h94
`define GPE_OFF_MASK0     8'h9C
`define GPE_OFF_MASK1     8'hA0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPE_RST_PINS      50'h0
`define GPE_RST_OE_N      50'h3FFFFFFFFFFFF
`define GPE_RST_WORD      32'h00000000

`endif

// ===== verilog/gpe_pkg.sv
// Types shared by the edge-detecting GPIO port
package gpe_pkg;
  `include "gpe_consts.svh"

  typedef logic [`GPE_ADDR_W-1:0] gpe_addr_type;
  typedef logic [`GPE_DATA_W-1:0] gpe_word_type;
  typedef logic [`GPE_BE_W-1:0]   gpe_be_type;
  typedef logic [`GPE_PINS-1:0]   gpe_pins_type;

  typedef enum logic [1:0] {
    GPE_IDLE = 2'h1,
    GPE_ACK  = 2'h2
  } gpe_bus_state_type;
endpackage : gpe_pkg

// ===== verilog/gpe_port.sv
// Fifty-pin GPIO port with edge detection behind an Avalon-MM slave
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`include "gpe_consts.svh"
// Contract
// - Bank zero has 32 pins, bank one 18; bank-one bits 31:18 read zero.
// - Pin-level registers are read-only and return each pin's synchronised level, two clocks behind the pin.
// - Direction bit: 0 input, 1 output; read/write; resets to input.
// - Output-set write of 1 drives an output pin high; 0 leaves it.
// - Output-clear write of 1 drives an output pin low; 0 leaves it.
// - Enabled rising edge sets the pin's status bit; disabled ones are ignored.
// - Enabled falling edge sets the pin's status bit; disabled ones are ignored.
// - Status bits stick until a 1 is written; reset to 0.
// - Direction-set write of 1 makes the pin an output; 0 leaves it.
// - Direction-clear write of 1 makes the pin an input; 0 leaves it.
module gpe_port (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire gpe_pkg::gpe_addr_type address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire gpe_pkg::gpe_word_type writedata,
  input  wire gpe_pkg::gpe_be_type   byteenable,
  output      gpe_pkg::gpe_word_type readdata,
  output logic                   waitrequest,
  input  wire gpe_pkg::gpe_pins_type pin_in,
  output      gpe_pkg::gpe_pins_type pin_out,
  output      gpe_pkg::gpe_pins_type pin_oe_n,
  output logic                   irq
);
  import gpe_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic gpe_word_type be_expand(input gpe_be_type be);
    gpe_word_type m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return m;
  endfunction : be_expand

  // Places a bus word onto the 50-pin vector of the bank its address selects
  function automatic gpe_pins_type place(input gpe_addr_type a, input gpe_addr_type o0,
                                         input gpe_addr_type o1, input gpe_word_type d);
    gpe_pins_type v;
    v = `GPE_RST_PINS;
    if (a == o0) begin
      v = {18'h00000, d};
    end else if (a == o1) begin
      v = {d[`GPE_BANK1_W-1:0], 32'h00000000};
    end
    return v;
  endfunction : place

  function automatic gpe_word_type bank(input gpe_pins_type v, input logic hi);
    gpe_word_type w;
    w = hi ? {14'h0000, v[`GPE_PINS-1:`GPE_BANK0_W]} : v[`GPE_BANK0_W-1:0];
    return w;
  endfunction : bank

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  gpe_bus_state_type state;
  gpe_pins_type      sync_meta;
  gpe_pins_type      lvl;
  gpe_pins_type      lvl_prev;
  gpe_pins_type      rise_en;
  gpe_pins_type      fall_en;
  gpe_pins_type      status;
  gpe_pins_type      mask;
  gpe_word_type      rd_word;

  // --------------------------------------------------------------------------
  // Write decode
  // --------------------------------------------------------------------------
  wire logic         wr_ack    = (state == GPE_ACK) && write;
  wire logic         rd_ack    = (state == GPE_ACK) && read;
  wire gpe_word_type wmask     = be_expand(byteenable);
  wire gpe_word_type wbits     = writedata & wmask;
  wire gpe_word_type wzero     = `GPE_RST_WORD;
  wire gpe_word_type wload     = wr_ack ? wmask : wzero;
  wire gpe_word_type wone      = wr_ack ? wbits : wzero;
  wire gpe_pins_type direction = ~pin_oe_n;

  wire gpe_pins_type dir_load  = place(address, `GPE_OFF_DIR0, `GPE_OFF_DIR1, wload);
  wire gpe_pins_type dir_val   = place(address, `GPE_OFF_DIR0, `GPE_OFF_DIR1, wbits);
  wire gpe_pins_type dir_set   = place(address, `GPE_OFF_DSET0, `GPE_OFF_DSET1, wone);
  wire gpe_pins_type dir_clr   = place(address, `GPE_OFF_DCLR0, `GPE_OFF_DCLR1, wone);
  wire gpe_pins_type out_set   = place(address, `GPE_OFF_OSET0, `GPE_OFF_OSET1, wone);
  wire gpe_pins_type out_clr   = place(address, `GPE_OFF_OCLR0, `GPE_OFF_OCLR1, wone);
  wire gpe_pins_type rise_load = place(address, `GPE_OFF_RISE0, `GPE_OFF_RISE1, wload);
  wire gpe_pins_type rise_val  = place(address, `GPE_OFF_RISE0, `GPE_OFF_RISE1, wbits);
  wire gpe_pins_type rise_set  = place(address, `GPE_OFF_RSET0, `GPE_OFF_RSET1, wone);
  wire gpe_pins_type rise_clr  = place(address, `GPE_OFF_RCLR0, `GPE_OFF_RCLR1, wone);
  wire gpe_pins_type fall_load = place(address, `GPE_OFF_FALL0, `GPE_OFF_FALL1, wload);
  wire gpe_pins_type fall_val  = place(address, `GPE_OFF_FALL0, `GPE_OFF_FALL1, wbits);
  wire gpe_pins_type fall_set  = place(address, `GPE_OFF_FSET0, `GPE_OFF_FSET1, wone);
  wire gpe_pins_type fall_clr  = place(address, `GPE_OFF_FCLR0, `GPE_OFF_FCLR1, wone);
  wire gpe_pins_type mask_load = place(address, `GPE_OFF_MASK0, `GPE_OFF_MASK1, wload);
  wire gpe_pins_type mask_val  = place(address, `GPE_OFF_MASK0, `GPE_OFF_MASK1, wbits);
  wire gpe_pins_type stat_clr  = place(address, `GPE_OFF_STAT0, `GPE_OFF_STAT1, wone);

  // --------------------------------------------------------------------------
  // Next values
  // --------------------------------------------------------------------------
  wire gpe_pins_type next_direction =
    ((direction & ~dir_load) | (dir_val & dir_load) | dir_set) & ~dir_clr;
  // Set and clear act only on pins that are outputs now
  wire gpe_pins_type next_out =
    (pin_out | (out_set & direction)) & ~(out_clr & direction);
  wire gpe_pins_type next_rise =
    ((rise_en & ~rise_load) | (rise_val & rise_load) | rise_set) & ~rise_clr;
  wire gpe_pins_type next_fall =
    ((fall_en & ~fall_load) | (fall_val & fall_load) | fall_set) & ~fall_clr;
  wire gpe_pins_type next_mask = (mask & ~mask_load) | (mask_val & mask_load);
  wire gpe_pins_type rise_ev   = lvl & ~lvl_prev & rise_en;
  wire gpe_pins_type fall_ev   = ~lvl & lvl_prev & fall_en;
  wire gpe_pins_type edge_ev   = rise_ev | fall_ev;
  // An edge in the cycle of its own clearing wins
  wire gpe_pins_type next_status = (status & ~stat_clr) | edge_ev;
  wire logic         next_irq    = |(next_status & next_mask);

  // --------------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------------
  always_comb begin
    rd_word = `GPE_RST_WORD;
    if (address == `GPE_OFF_LEVEL0) begin
      rd_word = bank(lvl, 1'b0);
    end else if (address == `GPE_OFF_LEVEL1) begin
      rd_word = bank(lvl, 1'b1);
    end else if (address == `GPE_OFF_DIR0) begin
      rd_word = bank(direction, 1'b0);
    end else if (address == `GPE_OFF_DIR1) begin
      rd_word = bank(direction, 1'b1);
    end else if (address == `GPE_OFF_RISE0) begin
      rd_word = bank(rise_en, 1'b0);
    end else if (address == `GPE_OFF_RISE1) begin
      rd_word = bank(rise_en, 1'b1);
    end else if (address == `GPE_OFF_FALL0) begin
      rd_word = bank(fall_en, 1'b0);
    end else if (address == `GPE_OFF_FALL1) begin
      rd_word = bank(fall_en, 1'b1);
    end else if (address == `GPE_OFF_STAT0) begin
      rd_word = bank(status, 1'b0);
    end else if (address == `GPE_OFF_STAT1) begin
      rd_word = bank(status, 1'b1);
    end else if (address == `GPE_OFF_MASK0) begin
      rd_word = bank(mask, 1'b0);
    end else if (address == `GPE_OFF_MASK1) begin
      rd_word = bank(mask, 1'b1);
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchroniser and edge history
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    sync_meta <= pin_in;
    lvl       <= sync_meta;
    lvl_prev  <= lvl;
  end

  // --------------------------------------------------------------------------
  // Bus handshake: one wait cycle, then waitrequest low for one cycle
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state       <= GPE_IDLE;
      waitrequest <= 1'b1;
      readdata    <= `GPE_RST_WORD;
    end else begin
      case (state)
        GPE_IDLE: begin
          if (read || write) begin
            state       <= GPE_ACK;
            waitrequest <= 1'b0;
            readdata    <= rd_word;
          end
        end
        GPE_ACK: begin
          state       <= GPE_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          state       <= GPE_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Port registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_oe_n <= `GPE_RST_OE_N;
      pin_out  <= `GPE_RST_PINS;
      rise_en  <= `GPE_RST_PINS;
      fall_en  <= `GPE_RST_PINS;
      status   <= `GPE_RST_PINS;
      mask     <= `GPE_RST_PINS;
      irq      <= 1'b0;
    end else begin
      pin_oe_n <= ~next_direction;
      pin_out  <= next_out;
      rise_en  <= next_rise;
      fall_en  <= next_fall;
      status   <= next_status;
      mask     <= next_mask;
      irq      <= next_irq;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  wire logic full_be = (byteenable == 4'hF);

  property p_bank1_reserved;
    @(posedge clk) disable iff (srst)
      ($fell(waitrequest) && $past(read) && $past(address) == `GPE_OFF_LEVEL1)
        |-> (readdata[31:18] == 14'h0000);
  endproperty
  a_bank1_reserved: assert property (p_bank1_reserved) else $error("bank one reserved bits not zero");

  property p_level_read;
    @(posedge clk) disable iff (srst)
      (rd_ack && address == `GPE_OFF_LEVEL0) |-> (readdata == $past(lvl[31:0]));
  endproperty
  a_level_read: assert property (p_level_read) else $error("pin level read mismatch");

  property p_dir_write;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_DIR0)
        |=> (pin_oe_n[31:0] == ~$past(writedata));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not applied");

  property p_out_set;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_OSET0)
        |=> (((pin_out[31:0] & $past(writedata & direction[31:0])) == $past(writedata & direction[31:0]))
             && ((pin_out[31:0] & ~$past(direction[31:0])) == $past(pin_out[31:0] & ~direction[31:0])));
  endproperty
  a_out_set: assert property (p_out_set) else $error("output set misbehaved");

  property p_out_clr;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_OCLR0)
        |=> (((pin_out[31:0] & $past(writedata & direction[31:0])) == 32'h00000000)
             && ((pin_out[31:0] & ~$past(writedata)) == $past(pin_out[31:0] & ~writedata)));
  endproperty
  a_out_clr: assert property (p_out_clr) else $error("output clear misbehaved");

  property p_rise_sets;
    @(posedge clk) disable iff (srst)
      (|(lvl & ~lvl_prev & rise_en)) |=> ((status & $past(lvl & ~lvl_prev & rise_en))
                                          == $past(lvl & ~lvl_prev & rise_en));
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rising edge not recorded");

  property p_fall_sets;
    @(posedge clk) disable iff (srst)
      (|(~lvl & lvl_prev & fall_en)) |=> ((status & $past(~lvl & lvl_prev & fall_en))
                                          == $past(~lvl & lvl_prev & fall_en));
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("falling edge not recorded");

  property p_status_sticky;
    @(posedge clk) disable iff (srst)
      1'b1 |=> ((($past(status) & ~status) & ~$past(stat_clr)) == `GPE_RST_PINS)
               && (((status & ~$past(status)) & ~$past(edge_ev)) == `GPE_RST_PINS);
  endproperty
  a_status_sticky: assert property (p_status_sticky) else $error("status bit changed without cause");

  property p_dir_set;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_DSET0)
        |=> ((pin_oe_n[31:0] | $past(writedata)) == $past(pin_oe_n[31:0] | writedata))
            && ((pin_oe_n[31:0] & $past(writedata)) == 32'h00000000);
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("direction set misbehaved");

  property p_dir_clr;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_DCLR0)
        |=> ((pin_oe_n[31:0] & $past(writedata)) == $past(writedata))
            && ((pin_oe_n[31:0] & ~$past(writedata)) == $past(pin_oe_n[31:0] & ~writedata));
  endproperty
  a_dir_clr: assert property (p_dir_clr) else $error("direction clear misbehaved");

  property p_sync_delay;
    @(posedge clk) disable iff (srst)
      ##3 (lvl == $past(pin_in, 2));
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("level not two cycles behind pin");

  property p_setclr_read_zero;
    @(posedge clk) disable iff (srst)
      (rd_ack && (address == `GPE_OFF_OSET0 || address == `GPE_OFF_DCLR1 || address == `GPE_OFF_FSET0))
        |-> (readdata == 32'h00000000);
  endproperty
  a_setclr_read_zero: assert property (p_setclr_read_zero) else $error("set or clear read not zero");

  property p_irq_level;
    @(posedge clk) disable iff (srst)
      irq == |(status & mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt disagrees with status and mask");

  property p_ack_one_cycle;
    @(posedge clk) disable iff (srst)
      $fell(waitrequest) |=> waitrequest;
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("waitrequest low too long");

  property p_rise_set_reg;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_RSET0)
        |=> (rise_en[31:0] == $past(rise_en[31:0] | writedata));
  endproperty
  a_rise_set_reg: assert property (p_rise_set_reg) else $error("rise enable set misbehaved");

  property p_rise_clr_reg;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_RCLR0)
        |=> (rise_en[31:0] == $past(rise_en[31:0] & ~writedata));
  endproperty
  a_rise_clr_reg: assert property (p_rise_clr_reg) else $error("rise enable clear misbehaved");

  property p_fall_set_reg;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_FSET1)
        |=> (fall_en[49:32] == $past(fall_en[49:32] | writedata[17:0]));
  endproperty
  a_fall_set_reg: assert property (p_fall_set_reg) else $error("fall enable set misbehaved");

  property p_fall_clr_reg;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_FCLR0)
        |=> (fall_en[31:0] == $past(fall_en[31:0] & ~writedata));
  endproperty
  a_fall_clr_reg: assert property (p_fall_clr_reg) else $error("fall enable clear misbehaved");

  property p_stat_clr;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_STAT0)
        |=> ((status[31:0] & $past(writedata & ~edge_ev[31:0])) == 32'h00000000);
  endproperty
  a_stat_clr: assert property (p_stat_clr) else $error("status write of one did not clear");

  property p_mask_write;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_MASK0)
        |=> (mask[31:0] == $past(writedata));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write not applied");

  property p_dir_set_bank1;
    @(posedge clk) disable iff (srst)
      (wr_ack && full_be && address == `GPE_OFF_DSET1)
        |=> (pin_oe_n[49:32] == $past(pin_oe_n[49:32] & ~writedata[17:0]));
  endproperty
  a_dir_set_bank1: assert property (p_dir_set_bank1) else $error("bank one direction set misbehaved");

  property p_lane_hold;
    @(posedge clk) disable iff (srst)
      (wr_ack && !byteenable[0] && address == `GPE_OFF_DIR0)
        |=> (pin_oe_n[7:0] == $past(pin_oe_n[7:0]));
  endproperty
  a_lane_hold: assert property (p_lane_hold) else $error("disabled byte lane was written");

  c_edge_seen:   cover property (@(posedge clk) disable iff (srst) |edge_ev);
  c_status_clr:  cover property (@(posedge clk) disable iff (srst) |(stat_clr & status));
  c_irq_rise:    cover property (@(posedge clk) disable iff (srst) $rose(irq));
  c_both_edges:  cover property (@(posedge clk) disable iff (srst) |(rise_en & fall_en & edge_ev));
  c_bank1_edge:  cover property (@(posedge clk) disable iff (srst) |edge_ev[49:32]);
endmodule : gpe_port

// ===== tb/gpe_pin_model.sv
// External pin model: the far side drives every pin the port leaves as input
`timescale 1ns/1ps
module gpe_pin_model
  import gpe_pkg::*;
(
  input  wire gpe_pkg::gpe_pins_type pin_out,
  input  wire gpe_pkg::gpe_pins_type pin_oe_n,
  input  wire gpe_pkg::gpe_pins_type ext_val,
  output      gpe_pkg::gpe_pins_type pin_in
);
  // Driven pins show the port's value, the rest the external level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_val);
endmodule : gpe_pin_model

// ===== tb/gpe_port_test.sv
// Self-checking bench for the edge-detecting GPIO port
`timescale 1ns/1ps
`include "gpe_consts.svh"
module gpe_port_test;
  import gpe_pkg::*;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  gpe_addr_type address = 8'h00;
  logic         read = 1'b0;
  logic         write = 1'b0;
  gpe_word_type writedata = 32'h00000000;
  gpe_be_type   byteenable = 4'hF;
  gpe_word_type readdata;
  logic         waitrequest;
  gpe_pins_type pin_in;
  gpe_pins_type pin_out;
  gpe_pins_type pin_oe_n;
  gpe_pins_type ext_val = 50'h0;
  logic         irq;
  int           fail_count = 0;
  int           n_checks = 0;

  always #12.5 clk = ~clk;

  gpe_port DUT (.clk(clk), .srst(srst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
  gpe_pin_model PINS (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .pin_in(pin_in));

  // ---------------------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input gpe_addr_type a, input gpe_word_type d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input gpe_addr_type a, output gpe_word_type d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_rd

  task automatic rd_chk(input string what, input gpe_addr_type a, input gpe_word_type exp);
    gpe_word_type v;
    bus_rd(a, v);
    chk(what, exp, v);
  endtask : rd_chk

  task automatic settle();
    repeat (5) @(posedge clk);
  endtask : settle

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk("oe_n", 64'h3FFFFFFFFFFFF, pin_oe_n);
    chk("irq", 0, irq);
    rd_chk("level0", `GPE_OFF_LEVEL0, 32'h00000000);
    rd_chk("dir1", `GPE_OFF_DIR1, 32'h00000000);
    rd_chk("stat0", `GPE_OFF_STAT0, 32'h00000000);
    rd_chk("mask1", `GPE_OFF_MASK1, 32'h00000000);
    bus_wr(8'hFC, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'hFC, 32'h00000000);
    rd_chk("dir0", `GPE_OFF_DIR0, 32'h00000000);
  endtask : t_reset

  task automatic t_direction();
    bus_wr(`GPE_OFF_DIR0, 32'h000000F0);
    rd_chk("dir0", `GPE_OFF_DIR0, 32'h000000F0);
    bus_wr(`GPE_OFF_DSET1, 32'hFFFFFFFF);
    rd_chk("dir1", `GPE_OFF_DIR1, 32'h0003FFFF);
    bus_wr(`GPE_OFF_DCLR1, 32'h0003FFF0);
    rd_chk("dir1", `GPE_OFF_DIR1, 32'h0000000F);
    byteenable <= 4'hE;
    bus_wr(`GPE_OFF_DIR0, 32'h00000000);
    byteenable <= 4'hF;
    rd_chk("dir0 lanes", `GPE_OFF_DIR0, 32'h000000F0);
    bus_wr(`GPE_OFF_DSET0, 32'h00000000);
    rd_chk("dset0", `GPE_OFF_DSET0, 32'h00000000);
    settle();
    chk("oe_n", {14'h0000, ~{18'h0000F, 32'h000000F0}}, pin_oe_n);
  endtask : t_direction

  task automatic t_output();
    bus_wr(`GPE_OFF_OSET0, 32'h000000FF);
    settle();
    chk("pin_out", 64'h00000000F0, pin_out);
    ext_val[0] <= 1'b1;
    settle();
    rd_chk("level0", `GPE_OFF_LEVEL0, 32'h000000F1);
    bus_wr(`GPE_OFF_OCLR0, 32'h00000031);
    settle();
    chk("pin_out", 64'h00000000C0, pin_out);
    rd_chk("oset0", `GPE_OFF_OSET0, 32'h00000000);
    rd_chk("oclr0", `GPE_OFF_OCLR0, 32'h00000000);
    bus_wr(`GPE_OFF_DCLR0, 32'h00000080);
    bus_wr(`GPE_OFF_OCLR0, 32'h00000080);
    settle();
    chk("pin_out input", 64'h00000000C0, pin_out);
    rd_chk("stat0", `GPE_OFF_STAT0, 32'h00000000);
    ext_val[0] <= 1'b0;
    settle();
  endtask : t_output

  task automatic t_edges();
    bus_wr(`GPE_OFF_RSET0, 32'h00000005);
    bus_wr(`GPE_OFF_FALL0, 32'h00000006);
    rd_chk("rise0", `GPE_OFF_RISE0, 32'h00000005);
    ext_val[2:0] <= 3'h7;
    settle();
    rd_chk("stat0", `GPE_OFF_STAT0, 32'h00000005);
    ext_val[2:0] <= 3'h0;
    settle();
    rd_chk("stat0", `GPE_OFF_STAT0, 32'h00000007);
    chk("irq", 0, irq);
    bus_wr(`GPE_OFF_MASK0, 32'h00000002);
    settle();
    chk("irq", 1, irq);
    bus_wr(`GPE_OFF_STAT0, 32'h00000002);
    rd_chk("stat0", `GPE_OFF_STAT0, 32'h00000005);
    bus_wr(`GPE_OFF_STAT0, 32'h00000000);
    rd_chk("stat0", `GPE_OFF_STAT0, 32'h00000005);
    settle();
    chk("irq", 0, irq);
    bus_wr(`GPE_OFF_RCLR0, 32'h00000001);
    rd_chk("rise0", `GPE_OFF_RISE0, 32'h00000004);
    bus_wr(`GPE_OFF_FCLR0, 32'h00000004);
    rd_chk("fall0", `GPE_OFF_FALL0, 32'h00000002);
    bus_wr(`GPE_OFF_STAT0, 32'h00000005);
  endtask : t_edges

  task automatic t_bank1();
    bus_wr(`GPE_OFF_FSET1, 32'hFFFE0000);
    rd_chk("fall1", `GPE_OFF_FALL1, 32'h00020000);
    ext_val[49] <= 1'b1;
    settle();
    rd_chk("level1", `GPE_OFF_LEVEL1, 32'h00020000);
    rd_chk("stat1", `GPE_OFF_STAT1, 32'h00000000);
    ext_val[49] <= 1'b0;
    settle();
    rd_chk("stat1", `GPE_OFF_STAT1, 32'h00020000);
    bus_wr(`GPE_OFF_MASK1, 32'h00020000);
    settle();
    chk("irq", 1, irq);
    bus_wr(`GPE_OFF_STAT1, 32'hFFFFFFFF);
    rd_chk("stat1", `GPE_OFF_STAT1, 32'h00000000);
    settle();
    chk("irq", 0, irq);
  endtask : t_bank1

  // ---------------------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset();
    t_direction();
    t_output();
    t_edges();
    t_bank1();
    close_out();
  end

  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule : gpe_port_test
